// >>> rsc_pkg.sv
// Constants and types shared by the reset source controller
package rsc_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_MHZ              = 250;
  localparam int STARTUP_DELAY_TIME_US = 64000;
  localparam int STARTUP_DELAY_CYCLES = STARTUP_DELAY_TIME_US * CLK_MHZ;
  localparam int DROP_DETECT_TIME_NS  = 2000;
  localparam int DROP_DETECT_CYCLES   = (DROP_DETECT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMPLE_WINDOW_CYCLES = 3;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] REG_CAUSE_OFS   = 8'h00;
  localparam logic [7:0] REG_CONTROL_OFS = 8'h04;
  localparam logic [7:0] REG_STATUS_OFS  = 8'h08;

  // reset_cause_status fields
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_EXT_BIT = 1;
  localparam int CAUSE_BOR_BIT = 2;
  localparam int CAUSE_WDT_BIT = 3;
  localparam logic [3:0] CAUSE_RESET = 4'h1;

  // control fields
  localparam int CTRL_CMP_REF_BIT = 0;
  localparam logic CTRL_RESET     = 1'b0;

  // status fields
  localparam int STAT_MODE_LSB   = 0;
  localparam int STAT_REF_BIT    = 2;
  localparam int STAT_POWER_BIT  = 3;
  localparam int STAT_FORCED_BIT = 4;
  localparam int STAT_BOD_BIT    = 5;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    RSC_MODE_RESERVED = 2'h0,
    RSC_MODE_SAMPLED  = 2'h1,
    RSC_MODE_ENABLED  = 2'h2,
    RSC_MODE_DISABLED = 2'h3
  } rsc_mode_t;

  localparam logic [1:0] FUSE_RESET = 2'h3;

  typedef enum logic [2:0] {
    RSC_ST_HOLD  = 3'h1,
    RSC_ST_COUNT = 3'h2,
    RSC_ST_RUN   = 3'h4
  } rsc_state_t;

endpackage

// >>> rsc_top.sv
// Reset source combiner, start-up delay, supply-drop detector and reference control
//
// Function
// - Internal reset restores registers; restart at vector
// - Power-on, pin and watchdog reset I/O asynchronously; drop resets it on a clock edge
// - Delay counter stretches reset after sources
// - Four sources: power-on, pin, watchdog, drop
// - Power-on detect asserts reset immediately
// - Power-on release starts the delay counter
// - Low pin resets; release after delay
// - Pin ignored during power-on count
// - Watchdog pulse; count starts at falling edge
// - Drop held detection time resets until recovered
// - Disabled mode never monitors nor resets
// - Sampled mode powers detector per tick fall
// - Sampled detection forces continuous until reset end
// - Active fuse field selects detector mode
// - Sleep fuse field selects mode, same codes
// - Reference on for detector, comparator, converter
// - Watchdog flag: set on event, clear power-on/zero
// - Power-on flag: set at power-on, zero clears
`timescale 1ns/10ps

module rsc_top
  import rsc_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_DELAY_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        por_detect,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        ext_reset_enable,
  input  wire logic        watchdog_timeout,
  input  wire logic        watchdog_enable,
  input  wire logic        drop_detector_out_n,
  input  wire logic        tick_1khz,
  input  wire logic [1:0]  active_drop_mode_select,
  input  wire logic [1:0]  sleep_drop_mode_select,
  input  wire logic        deep_sleep,
  input  wire logic        adc_enable,
  output logic             internal_reset,
  output logic             io_reset_n,
  output logic             drop_detector_power,
  output logic             bandgap_enable
);

  // ************************************************************
  // Asynchronous reset terms
  // ************************************************************
  // Power-on and system reset clear everything, without a clock
  wire logic hard_rst_n;
  // I/O reset also reacts to the pin and watchdog with no clock running
  wire logic io_async_n;

  assign hard_rst_n = presetn & ~por_detect;
  assign io_async_n = hard_rst_n & ~(ext_reset_enable & ~ext_reset_pin_n)
                      & ~(watchdog_enable & watchdog_timeout);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Bits: 0 pin low, 1 watchdog, 2 drop low, 3 tick
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       tick_d_q;
  wire  logic [3:0] raw_in;

  assign raw_in = {tick_1khz, ~drop_detector_out_n, watchdog_timeout, ~ext_reset_pin_n};

  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      sync1_q  <= 4'h0;
      sync2_q  <= 4'h0;
      tick_d_q <= 1'b0;
    end else begin
      sync1_q  <= raw_in;
      sync2_q  <= sync1_q;
      tick_d_q <= sync2_q[3];
    end
  end

  wire logic pin_low_s;
  wire logic wdt_s;
  wire logic drop_low_s;
  wire logic tick_fall;

  assign pin_low_s  = sync2_q[0];
  assign wdt_s      = sync2_q[1];
  assign drop_low_s = sync2_q[2];
  assign tick_fall  = tick_d_q & ~sync2_q[3];

  // ************************************************************
  // Detector mode selection
  // ************************************************************
  logic [1:0] act_fuse_q;
  logic [1:0] slp_fuse_q;
  logic       forced_cont_q;
  logic       bod_rst_q;
  logic [9:0] low_cnt_q;
  logic [SAMPLE_WINDOW_CYCLES-1:0] sample_pend_q;
  rsc_state_t state_q;
  rsc_state_t state_d;

  wire logic [1:0] fuse_sel;
  wire logic       mode_cont;
  wire logic       mode_sampled;
  wire logic       mode_off;

  assign fuse_sel     = deep_sleep ? slp_fuse_q : act_fuse_q;
  assign mode_cont    = forced_cont_q || (fuse_sel == RSC_MODE_ENABLED);
  assign mode_sampled = !forced_cont_q && (fuse_sel == RSC_MODE_SAMPLED);
  // Reserved code is treated as disabled so an unprogrammed part stays quiet
  assign mode_off     = !mode_cont && !mode_sampled;

  // Fuses are re-read throughout reset and frozen while running
  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      act_fuse_q <= FUSE_RESET;
      slp_fuse_q <= FUSE_RESET;
    end else if (state_q != RSC_ST_RUN) begin
      act_fuse_q <= active_drop_mode_select;
      slp_fuse_q <= sleep_drop_mode_select;
    end
  end

  // ************************************************************
  // Supply-drop detection
  // ************************************************************
  wire logic low_long;
  wire logic sample_hit;

  assign low_long   = (low_cnt_q == 10'(DROP_DETECT_CYCLES - 1)) && drop_low_s;
  assign sample_hit = mode_sampled && sample_pend_q[SAMPLE_WINDOW_CYCLES-1] && drop_low_s;

  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      low_cnt_q <= 10'h000;
    end else if (!mode_cont || !drop_low_s) begin
      low_cnt_q <= 10'h000;
    end else if (!low_long) begin
      low_cnt_q <= low_cnt_q + 10'h001;
    end
  end

  // Sample window: detector powered a few cycles to cover the synchroniser lag
  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      sample_pend_q <= '0;
    end else begin
      sample_pend_q <= {sample_pend_q[SAMPLE_WINDOW_CYCLES-2:0],
                        mode_sampled & tick_fall};
    end
  end

  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      bod_rst_q <= 1'b0;
    end else if (mode_off || !drop_low_s) begin
      bod_rst_q <= 1'b0;
    end else if (low_long || sample_hit) begin
      bod_rst_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      forced_cont_q <= 1'b0;
    end else if (sample_hit) begin
      forced_cont_q <= 1'b1;
    end else if (state_q == RSC_ST_COUNT && state_d == RSC_ST_RUN) begin
      forced_cont_q <= 1'b0;
    end
  end

  // ************************************************************
  // Reset sequencing
  // ************************************************************
  logic        por_phase_q;
  logic [31:0] delay_cnt_q;
  logic [31:0] delay_cnt_d;

  wire logic ext_src;
  wire logic wdt_src;
  wire logic any_src;
  wire logic count_done;

  assign ext_src    = ext_reset_enable & pin_low_s & ~por_phase_q;
  assign wdt_src    = watchdog_enable & wdt_s;
  assign any_src    = ext_src | wdt_src | bod_rst_q;
  assign count_done = delay_cnt_q == 32'(STARTUP_CYCLES - 1);

  always_comb begin
    state_d     = state_q;
    delay_cnt_d = 32'h0;
    unique case (state_q)
      RSC_ST_HOLD: begin
        if (!any_src) begin
          state_d = RSC_ST_COUNT;
        end
      end
      RSC_ST_COUNT: begin
        if (any_src) begin
          state_d = RSC_ST_HOLD;
        end else if (!count_done) begin
          delay_cnt_d = delay_cnt_q + 32'h1;
        end else if (por_phase_q && ext_reset_enable && pin_low_s) begin
          state_d = RSC_ST_HOLD;
        end else begin
          state_d = RSC_ST_RUN;
        end
      end
      RSC_ST_RUN: begin
        if (any_src) begin
          state_d = RSC_ST_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      state_q     <= RSC_ST_HOLD;
      delay_cnt_q <= 32'h0;
      por_phase_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      delay_cnt_q <= delay_cnt_d;
      if (state_q == RSC_ST_COUNT && count_done) begin
        por_phase_q <= 1'b0;
      end
    end
  end

  // Release only on a clock edge; assertion is immediate through hard_rst_n
  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      internal_reset <= 1'b1;
    end else begin
      internal_reset <= (state_d != RSC_ST_RUN);
    end
  end

  always_ff @(posedge pclk or negedge io_async_n) begin
    if (!io_async_n) begin
      io_reset_n <= 1'b0;
    end else begin
      io_reset_n <= (state_d == RSC_ST_RUN);
    end
  end

  // ************************************************************
  // Detector power and bandgap reference
  // ************************************************************
  logic cmp_ref_q;

  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      drop_detector_power <= 1'b0;
      bandgap_enable      <= 1'b0;
    end else begin
      drop_detector_power <= mode_cont | (mode_sampled & (tick_fall | (|sample_pend_q)));
      bandgap_enable      <= !mode_off | cmp_ref_q | adc_enable;
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  logic [3:0] cause_q;
  logic       bod_rst_d1_q;

  wire logic apb_setup;
  wire logic apb_write;
  wire logic hit_cause;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic [31:0] rd_mux;
  wire logic [3:0]  cause_set;
  wire logic [3:0]  cause_keep;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;
  assign hit_cause = paddr == REG_CAUSE_OFS;
  assign hit_ctrl  = paddr == REG_CONTROL_OFS;
  assign hit_stat  = paddr == REG_STATUS_OFS;

  assign rd_mux = hit_cause ? {28'h0, cause_q} :
                  hit_ctrl  ? {31'h0, cmp_ref_q} :
                  hit_stat  ? {26'h0, bod_rst_q, forced_cont_q, drop_detector_power,
                               bandgap_enable, fuse_sel} :
                  32'h0;

  // Software clears a flag by writing zero; a same-cycle event still sets it
  assign cause_keep = (apb_write && hit_cause) ? (cause_q & pwdata[3:0]) : cause_q;
  assign cause_set[CAUSE_POR_BIT] = 1'b0;
  assign cause_set[CAUSE_EXT_BIT] = ext_src & (state_q == RSC_ST_RUN);
  assign cause_set[CAUSE_BOR_BIT] = bod_rst_q & ~bod_rst_d1_q;
  assign cause_set[CAUSE_WDT_BIT] = wdt_src & (state_q == RSC_ST_RUN);

  // Power-on reset sets the power-on flag and clears the rest
  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      cause_q      <= CAUSE_RESET;
      bod_rst_d1_q <= 1'b0;
    end else begin
      cause_q      <= cause_keep | cause_set;
      bod_rst_d1_q <= bod_rst_q;
    end
  end

  // Control register returns to its initial value under internal reset
  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      cmp_ref_q <= CTRL_RESET;
    end else if (internal_reset) begin
      cmp_ref_q <= CTRL_RESET;
    end else if (apb_write && hit_ctrl) begin
      cmp_ref_q <= pwdata[CTRL_CMP_REF_BIT];
    end
  end

  always_ff @(posedge pclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= ~(hit_cause | hit_ctrl | hit_stat);
      end
    end
  end

endmodule

// >>> rsc_model.sv
// Model of the reset sources: supply monitors, reset pin and watchdog
`timescale 1ns/10ps

module rsc_model #(
  parameter int TICK_HALF = 50
) (
  input  wire logic pclk,
  input  wire logic supply_low,
  input  wire logic supply_drop,
  input  wire logic pin_low,
  input  wire logic wdt_fire,
  output logic      por_detect,
  output logic      ext_reset_pin_n,
  output logic      watchdog_timeout,
  output logic      drop_detector_out_n,
  output logic      tick_1khz
);
  int tick_cnt = 0;
  int wdt_cnt  = 0;
  logic fire_q = 1'b0;

  assign por_detect          = supply_low;
  assign drop_detector_out_n = !supply_drop;
  assign ext_reset_pin_n     = !pin_low;
  assign watchdog_timeout    = wdt_cnt != 0;
  // Scaled tick: runs free, one sample per period
  assign tick_1khz           = tick_cnt >= TICK_HALF;

  always @(posedge pclk) begin
    tick_cnt <= (tick_cnt == 2 * TICK_HALF - 1) ? 0 : tick_cnt + 1;
    fire_q <= wdt_fire;
    // One short pulse per request edge, a held level would stall the count
    if (wdt_fire && !fire_q && wdt_cnt == 0)
      wdt_cnt <= 3;
    else if (wdt_cnt != 0)
      wdt_cnt <= wdt_cnt - 1;
  end
endmodule

// >>> rsc_chk.sv
// Assertions on the reset source controller ports
`timescale 1ns/10ps

module rsc_chk
  import rsc_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_DELAY_CYCLES
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       por_detect,
  input wire logic       ext_reset_pin_n,
  input wire logic       ext_reset_enable,
  input wire logic       watchdog_timeout,
  input wire logic       watchdog_enable,
  input wire logic       drop_detector_out_n,
  input wire logic [1:0] active_drop_mode_select,
  input wire logic [1:0] sleep_drop_mode_select,
  input wire logic       adc_enable,
  input wire logic       internal_reset,
  input wire logic       io_reset_n,
  input wire logic       drop_detector_power,
  input wire logic       bandgap_enable
);
  localparam int DROP_LIM = DROP_DETECT_CYCLES + 10;
  int  rel_cnt;
  int  low_cnt;
  wire src_on = por_detect || (ext_reset_enable && !ext_reset_pin_n) ||
                (watchdog_enable && watchdog_timeout);
  wire [3:0] fuses  = {active_drop_mode_select, sleep_drop_mode_select};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Counts from source release, ahead of the design's synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_cnt <= 0;
      low_cnt <= 0;
    end else begin
      rel_cnt <= src_on ? 0 : rel_cnt + 1;
      low_cnt <= (fuses == 4'ha && !drop_detector_out_n) ? low_cnt + 1 : 0;
    end
  end

  sequence wdt_end_s;
    $fell(watchdog_timeout) ##0 watchdog_enable;
  endsequence

  por_now_a: assert property (por_detect |-> internal_reset && !io_reset_n)
    else $error("power-on detect did not hold reset");
  pin_io_a: assert property (ext_reset_enable && !ext_reset_pin_n && !internal_reset |-> !io_reset_n)
    else $error("pin low did not reset the ports");
  wdt_io_a: assert property (watchdog_enable && watchdog_timeout |-> !io_reset_n)
    else $error("watchdog pulse did not reset the ports");
  wdt_hold_a: assert property (wdt_end_s |=> internal_reset [*8])
    else $error("reset not held after watchdog pulse");
  stretch_min_a: assert property ($fell(internal_reset) |-> rel_cnt >= STARTUP_CYCLES)
    else $error("reset released before the delay count");
  io_release_a: assert property ($rose(io_reset_n) |-> $fell(internal_reset))
    else $error("port reset released apart from internal reset");
  brown_set_a: assert property (low_cnt == DROP_LIM |-> internal_reset)
    else $error("held supply drop gave no reset");
  off_mode_a: assert property (fuses == 4'hf |-> !drop_detector_power)
    else $error("detector powered in disabled mode");
  on_mode_a: assert property (fuses == 4'ha && !internal_reset |-> drop_detector_power)
    else $error("detector unpowered in enabled mode");
  samp_pulse_a: assert property ($rose(drop_detector_power) && fuses == 4'h5 &&
    drop_detector_out_n |-> drop_detector_power [*4] ##1 !drop_detector_power)
    else $error("sampling power pulse has wrong length");
  adc_ref_a: assert property (adc_enable |=> bandgap_enable)
    else $error("reference off while converter enabled");
endmodule

bind rsc_top rsc_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) rsc_chk_i (.*);

// >>> tb.sv
// Self-checking testbench for the reset source controller
`timescale 1ns/10ps

module tb;
  import rsc_pkg::*;
  localparam int SU = 20;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, por_detect, ext_reset_pin_n, watchdog_timeout, tick_1khz;
  logic        drop_detector_out_n, internal_reset, io_reset_n, drop_detector_power;
  logic        bandgap_enable, ext_reset_enable = 1'b1, watchdog_enable = 1'b1;
  logic        deep_sleep = 1'b0, adc_enable = 1'b0, supply_low = 1'b0, supply_drop = 1'b0;
  logic        pin_low = 1'b0, wdt_fire = 1'b0;
  logic [1:0]  active_drop_mode_select = 2'h3, sleep_drop_mode_select = 2'h3;
  int          num_errors = 0, n_compared = 0, cyc = 0;

  rsc_top #(.STARTUP_CYCLES(SU)) rsc_top_i (.*);
  rsc_model rsc_model_i (.*);

  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(n, {r[30:0], e}, {x[30:0], a > REG_STATUS_OFS});
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (internal_reset !== 1'b0 && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    check("released", internal_reset, 1'b0);
  endtask

  task automatic do_reset(input logic [1:0] a, s, input logic ds, output int n);
    @(posedge pclk);
    presetn <= 1'b0;
    active_drop_mode_select <= a;
    sleep_drop_mode_select  <= s;
    deep_sleep              <= ds;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_run(n);
  endtask

  // Source select: 0 watchdog, 1 supply low, 2 pin low, 3 supply drop
  task automatic set_src(input int which, input logic v);
    case (which)
      0: wdt_fire <= v;
      1: supply_low <= v;
      2: pin_low <= v;
      default: supply_drop <= v;
    endcase
  endtask

  // Drives one source for a while, then waits out the delay count
  task automatic src_reset(input int which, input int hold, input logic [31:0] cause);
    int n;
    wr(REG_CAUSE_OFS, 32'h0);
    set_src(which, 1'b1);
    repeat (hold) @(negedge pclk);
    check("held", internal_reset, 1'b1);
    @(posedge pclk);
    set_src(which, 1'b0);
    wait_run(n);
    check("stretch", n >= SU, 1'b1);
    rd_chk("cause", REG_CAUSE_OFS, cause);
  endtask

  task automatic pulse_len(output int n);
    n = 0;
    while (drop_detector_power !== 1'b1 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (drop_detector_power === 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_power_up();
    int n;
    do_reset(2'h3, 2'h3, 1'b0, n);
    check("startup", n >= SU && n <= SU + 4, 1'b1);
    rd_chk("cause", REG_CAUSE_OFS, 32'h1);
    rd_chk("unmapped", 8'h40, 32'h0);
    wr(REG_CAUSE_OFS, 32'h0);
    rd_chk("cause", REG_CAUSE_OFS, 32'h0);
    wr(REG_CONTROL_OFS, 32'h1);
    rd_chk("control", REG_CONTROL_OFS, 32'h1);
    // Reference follows the control bit while the detector is disabled
    check("bandgap", bandgap_enable, 1'b1);
    wr(REG_CONTROL_OFS, 32'h0);
    repeat (2) @(negedge pclk);
    check("bandgap", bandgap_enable, 1'b0);
    @(posedge pclk);
    adc_enable <= 1'b1;
    repeat (2) @(posedge pclk);
    adc_enable <= 1'b0;
  endtask

  task automatic t_sources();
    int n;
    watchdog_enable <= 1'b0;
    ext_reset_enable <= 1'b0;
    wdt_fire <= 1'b1;
    pin_low <= 1'b1;
    repeat (12) @(negedge pclk);
    check("gated", internal_reset, 1'b0);
    @(posedge pclk);
    pin_low <= 1'b0;
    wdt_fire <= 1'b0;
    repeat (6) @(posedge pclk);
    watchdog_enable <= 1'b1;
    ext_reset_enable <= 1'b1;
    src_reset(0, 6, 32'h8);
    src_reset(1, 5, 32'h1);
    src_reset(2, 6, 32'h2);
    do_reset(2'h3, 2'h3, 1'b0, n);
    src_reset(2, SU + 10, 32'h2);
  endtask

  task automatic t_modes();
    logic [4:0] tab [5] = '{5'h1e, 5'h16, 5'h06, 5'h1d, 5'h17};
    logic [4:0] pwr = 5'b01010;
    int n;
    foreach (tab[i]) begin
      do_reset(tab[i][4:3], tab[i][2:1], tab[i][0], n);
      repeat (3) @(negedge pclk);
      check("power", drop_detector_power, pwr[4 - i]);
      check("reference", bandgap_enable, pwr[4 - i]);
    end
    do_reset(2'h2, 2'h2, 1'b0, n);
    // A drop shorter than the detection time must not reset
    @(posedge pclk);
    supply_drop <= 1'b1;
    repeat (400) @(negedge pclk);
    check("early", internal_reset, 1'b0);
    @(posedge pclk);
    supply_drop <= 1'b0;
    repeat (4) @(posedge pclk);
    src_reset(3, 520, 32'h4);
    do_reset(2'h1, 2'h1, 1'b0, n);
    pulse_len(n);
    check("sample", n, 32'h4);
    src_reset(3, 120, 32'h4);
    pulse_len(n);
    check("sample", n, 32'h4);
  endtask

  initial begin
    t_power_up();
    t_sources();
    t_modes();
    test_done();
  end
endmodule
